/* File: design/crq_request_queues.sv */
// Implicit request nodes, their two queues and the coprocessor arbiter.
// Assumes the kernel holds post_req until post_ack and that the CPU
// arbiter and kernel_accept are single-cycle pulses on clk.
//
// The placing of the registers and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
`default_nettype none

module crq_request_queues (
   input  wire logic                          clk,
   input  wire logic                          rst_n,
   input  wire logic [crq_pkg::ADDR_W-1:0]    avs_address,
   input  wire logic                          avs_read,
   input  wire logic                          avs_write,
   input  wire logic [crq_pkg::DATA_W-1:0]    avs_writedata,
   input  wire logic [3:0]                    avs_byteenable,
   output var  logic [crq_pkg::DATA_W-1:0]    avs_readdata,
   output logic                               avs_waitrequest,
   input  wire logic                          post_req,
   input  wire crq_pkg::crq_post_s            post_info,
   output logic                               post_ack,
   output logic                               kernel_stall,
   output logic                               cpu_queue_full,
   output logic                               self_queue_full,
   output var  crq_pkg::crq_node_s [1:0]      cpu_nodes,
   input  wire logic [1:0]                    cpu_ack,
   input  wire logic                          ext_req,
   input  wire logic [crq_pkg::PRIO_W-1:0]    ext_prio,
   output logic                               ext_ack,
   input  wire logic                          kernel_accept,
   output var  logic                          winner_valid,
   output var  logic [crq_pkg::PRIO_W-1:0]    pending_winner_priority,
   output var  logic [1:0]                    winner_src,
   output logic                               irq
);

   // Lowest free entry of a two-entry queue, one-hot
   function automatic logic [1:0] first_free(input logic [1:0] pend);
      logic [1:0] slot;
      slot = 2'h0;
      if (!pend[0])
         slot = 2'h1;
      else if (!pend[1])
         slot = 2'h2;
      return slot;
   endfunction

   function automatic logic [31:0] node_word(input crq_pkg::crq_node_s n,
                                             input logic [1:0] service_target_select);
      logic [31:0] w;
      w = 32'h0;
      w[crq_pkg::NODE_PRIO_LSB +: crq_pkg::PRIO_W] = n.prio;
      w[crq_pkg::NODE_TOS_LSB +: 2] = service_target_select;
      w[crq_pkg::NODE_EN_BIT] = crq_pkg::EN_FIXED;
      w[crq_pkg::NODE_PEND_BIT] = n.pend;
      return w;
   endfunction

   crq_pkg::crq_node_s [3:0]     node_ff;
   crq_pkg::crq_node_s [3:0]     nxt_node;
   logic [3:0]                   pend;
   logic [3:0]                   set_vec;
   logic [3:0]                   clr_vec;

   logic [2:0]                   arb_ctrl_ff;
   logic [crq_pkg::PRIO_W-1:0]   err_prio_ff;
   logic [crq_pkg::IRQ_W-1:0]    irq_status_ff;
   logic [crq_pkg::IRQ_W-1:0]    nxt_irq_status;
   logic [crq_pkg::IRQ_W-1:0]    irq_mask_ff;
   logic [crq_pkg::IRQ_W-1:0]    events;
   logic [crq_pkg::IRQ_W-1:0]    rd_clr_bits_ff;

   crq_pkg::crq_arb_e            arb_state_ff;
   crq_pkg::crq_arb_e            nxt_arb_state;
   logic [1:0]                   arb_cyc_ff;
   logic [1:0]                   nxt_arb_cyc;
   logic                         arb_half_ff;
   logic                         nxt_arb_half;
   logic                         special_ff;
   logic                         nxt_special;
   logic [1:0]                   nxt_win_src;
   logic [crq_pkg::PRIO_W-1:0]   nxt_win_prio;
   logic                         self_full_q_ff;
   logic                         cpu_full_q_ff;
   logic                         stall_q_ff;

   logic                         done_ff;
   logic [crq_pkg::DATA_W-1:0]   rd_mux;

   // Node pending vector and the queue full indications
   genvar g;
   for (g = 0; g < 4; g++) begin : g_pend
      assign pend[g] = node_ff[g].pend;
   end

   assign cpu_queue_full  = pend[0] & pend[1];
   assign self_queue_full = pend[2] & pend[3];
   assign cpu_nodes       = node_ff[1:0];

   // Posting path from the kernel
   wire post_valid = post_info.from_error
                   | (post_info.int_bit & post_info.cond_true);
   wire post_to_self = ~post_info.from_error
                     & (post_info.target == crq_pkg::TOS_SELF);
   wire [crq_pkg::PRIO_W-1:0] post_prio = post_info.from_error
                     ? err_prio_ff : post_info.prio;
   // Only the queue actually addressed can hold the kernel
   wire tgt_full = post_to_self ? self_queue_full : cpu_queue_full;
   assign kernel_stall = post_req & post_valid & tgt_full;
   assign post_ack     = post_req & ~kernel_stall;
   wire do_post = post_req & post_valid & ~tgt_full;

   wire [1:0] cpu_slot  = first_free(pend[1:0]);
   wire [1:0] self_slot = first_free(pend[3:2]);
   assign set_vec = !do_post ? 4'h0
                  : post_to_self ? {self_slot, 2'h0}
                  : {2'h0, cpu_slot};

   // Arbiter decode
   wire self_full_rise = self_queue_full & ~self_full_q_ff;
   wire excl_ext       = self_queue_full | special_ff;
   wire any_req  = pend[2] | pend[3] | (ext_req & ~self_queue_full);
   wire [1:0] cyc_cfg = arb_ctrl_ff[crq_pkg::ARB_CNT_LSB +: 2];
   wire one_cfg  = arb_ctrl_ff[crq_pkg::ARB_ONE_BIT];
   wire clk_last = one_cfg | arb_half_ff;
   wire round_last = (arb_cyc_ff == cyc_cfg) & clk_last;
   wire accept = (arb_state_ff == crq_pkg::ARB_HOLD) & kernel_accept;
   // Winner source decode shared by restart and acknowledges;
   // registered, so it stays steady through the whole hold
   wire win_ext   = winner_src == crq_pkg::SRC_EXT;
   wire win_node2 = winner_src == crq_pkg::SRC_NODE2;
   wire win_node3 = winner_src == crq_pkg::SRC_NODE3;
   // A full self queue voids a round that an external source may win
   wire restart = self_full_rise
                & ((arb_state_ff == crq_pkg::ARB_RUN)
                 | ((arb_state_ff == crq_pkg::ARB_HOLD)
                  & win_ext
                  & ~accept));
   assign ext_ack = accept & win_ext;
   assign clr_vec = {accept & win_node3,
                     accept & win_node2,
                     cpu_ack};

   // Highest priority among participants; ties go to the lower node
   logic                       sel_ok;
   logic [1:0]                 sel_src;
   logic [crq_pkg::PRIO_W-1:0] sel_prio;
   always_comb begin
      sel_ok   = 1'b0;
      sel_src  = crq_pkg::SRC_NODE2;
      sel_prio = '0;
      if (pend[2]) begin
         sel_ok   = 1'b1;
         sel_prio = node_ff[2].prio;
      end
      if (pend[3] && (!sel_ok || node_ff[3].prio > sel_prio)) begin
         sel_ok   = 1'b1;
         sel_src  = crq_pkg::SRC_NODE3;
         sel_prio = node_ff[3].prio;
      end
      // Ties lose to self nodes; high self priorities keep the queue short
      if (ext_req && !excl_ext
          && (!sel_ok || ext_prio > sel_prio)) begin
         sel_ok   = 1'b1;
         sel_src  = crq_pkg::SRC_EXT;
         sel_prio = ext_prio;
      end
   end

   always_comb begin
      nxt_arb_state = arb_state_ff;
      nxt_arb_cyc   = arb_cyc_ff;
      nxt_arb_half  = arb_half_ff;
      nxt_special   = special_ff;
      nxt_win_src   = winner_src;
      nxt_win_prio  = pending_winner_priority;
      case (arb_state_ff)
         crq_pkg::ARB_IDLE: begin
            if (any_req) begin
               nxt_arb_state = crq_pkg::ARB_RUN;
               nxt_arb_cyc   = 2'h0;
               nxt_arb_half  = 1'b0;
               nxt_special   = self_queue_full;
            end
         end
         crq_pkg::ARB_RUN: begin
            if (restart) begin
               nxt_arb_cyc  = 2'h0;
               nxt_arb_half = 1'b0;
               nxt_special  = 1'b1;
            end else if (round_last) begin
               nxt_arb_state = sel_ok ? crq_pkg::ARB_HOLD
                                      : crq_pkg::ARB_IDLE;
               nxt_win_src   = sel_src;
               nxt_win_prio  = sel_prio;
            end else if (clk_last) begin
               nxt_arb_cyc  = 2'(arb_cyc_ff + 2'h1);
               nxt_arb_half = 1'b0;
            end else begin
               nxt_arb_half = 1'b1;
            end
         end
         crq_pkg::ARB_HOLD: begin
            if (accept) begin
               nxt_arb_state = crq_pkg::ARB_IDLE;
               nxt_special   = 1'b0;
            end else if (restart) begin
               nxt_arb_state = crq_pkg::ARB_RUN;
               nxt_arb_cyc   = 2'h0;
               nxt_arb_half  = 1'b0;
               nxt_special   = 1'b1;
            end
         end
         default: begin
            nxt_arb_state = crq_pkg::ARB_IDLE;
         end
      endcase
   end

   wire enter_special = nxt_special & (nxt_arb_state == crq_pkg::ARB_RUN)
                      & ((arb_state_ff == crq_pkg::ARB_IDLE) | restart);

   // Node update: a set always wins over an acknowledge
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         nxt_node[i].pend = set_vec[i] | (pend[i] & ~clr_vec[i]);
         nxt_node[i].prio = set_vec[i] ? post_prio
                                       : node_ff[i].prio;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         node_ff <= '0;
      end else begin
         node_ff <= nxt_node;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         arb_state_ff            <= crq_pkg::ARB_IDLE;
         arb_cyc_ff              <= 2'h0;
         arb_half_ff             <= 1'b0;
         special_ff              <= 1'b0;
         winner_src              <= crq_pkg::SRC_NODE2;
         pending_winner_priority <= '0;
         winner_valid            <= 1'b0;
      end else begin
         arb_state_ff            <= nxt_arb_state;
         arb_cyc_ff              <= nxt_arb_cyc;
         arb_half_ff             <= nxt_arb_half;
         special_ff              <= nxt_special;
         winner_src              <= nxt_win_src;
         pending_winner_priority <= nxt_win_prio;
         winner_valid            <= nxt_arb_state == crq_pkg::ARB_HOLD;
      end
   end

   // Interrupt events, edge detected
   assign events[crq_pkg::IRQ_CPU_FULL]  = cpu_queue_full & ~cpu_full_q_ff;
   assign events[crq_pkg::IRQ_SELF_FULL] = self_full_rise;
   assign events[crq_pkg::IRQ_STALL]     = kernel_stall & ~stall_q_ff;
   assign events[crq_pkg::IRQ_SPECIAL]   = enter_special;

   // Avalon slave: one wait state, answer on the second cycle
   wire bus_req = avs_read | avs_write;
   assign avs_waitrequest = bus_req & ~done_ff;
   wire first_cyc = bus_req & ~done_ff;
   wire wr_take   = avs_write & done_ff & avs_byteenable[0];
   wire rd_status = avs_read & done_ff
                  & (avs_address == crq_pkg::IDX_IRQ_STATUS);
   // Only bits already shown to software are cleared by the read
   assign nxt_irq_status = events
                         | (irq_status_ff
                            & ~(rd_status ? rd_clr_bits_ff : 4'h0));
   assign irq = |(irq_status_ff & irq_mask_ff);

   logic [31:0] arb_status_word;
   always_comb begin
      arb_status_word = 32'h0;
      arb_status_word[crq_pkg::ST_WIN_LSB +: crq_pkg::PRIO_W] =
         pending_winner_priority;
      arb_status_word[crq_pkg::ST_WIN_VALID] = winner_valid;
      arb_status_word[crq_pkg::ST_SELF_FULL] = self_queue_full;
      arb_status_word[crq_pkg::ST_CPU_FULL]  = cpu_queue_full;
      arb_status_word[crq_pkg::ST_STALL]     = kernel_stall;
      arb_status_word[crq_pkg::ST_SPECIAL]   = special_ff;
      arb_status_word[crq_pkg::ST_SRC_LSB +: 2] = winner_src;
   end

   always_comb begin
      case (avs_address)
         4'h0:    rd_mux = node_word(node_ff[0], crq_pkg::TOS_CPU);
         4'h1:    rd_mux = node_word(node_ff[1], crq_pkg::TOS_CPU);
         4'h2:    rd_mux = node_word(node_ff[2], crq_pkg::TOS_SELF);
         4'h3:    rd_mux = node_word(node_ff[3], crq_pkg::TOS_SELF);
         crq_pkg::IDX_ARB_CTRL:    rd_mux = {29'h0, arb_ctrl_ff};
         crq_pkg::IDX_GLOBAL_CTRL: rd_mux = {24'h0, err_prio_ff};
         crq_pkg::IDX_ARB_STATUS:  rd_mux = arb_status_word;
         crq_pkg::IDX_IRQ_STATUS:  rd_mux = {28'h0, irq_status_ff};
         crq_pkg::IDX_IRQ_MASK:    rd_mux = {28'h0, irq_mask_ff};
         default:                  rd_mux = 32'h0;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         done_ff        <= 1'b0;
         avs_readdata   <= 32'h0;
         rd_clr_bits_ff <= 4'h0;
      end else begin
         done_ff <= first_cyc;
         if (first_cyc && avs_read) begin
            avs_readdata   <= rd_mux;
            rd_clr_bits_ff <= irq_status_ff;
         end
      end
   end

   // Node words are absent here: software writes to them do nothing
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         arb_ctrl_ff <= crq_pkg::ARB_CTRL_RST;
         err_prio_ff <= crq_pkg::ERR_PRIO_RST;
         irq_mask_ff <= crq_pkg::IRQ_MASK_RST;
      end else if (wr_take) begin
         if (avs_address == crq_pkg::IDX_ARB_CTRL)
            arb_ctrl_ff <= avs_writedata[2:0];
         if (avs_address == crq_pkg::IDX_GLOBAL_CTRL)
            err_prio_ff <= avs_writedata[7:0];
         if (avs_address == crq_pkg::IDX_IRQ_MASK)
            irq_mask_ff <= avs_writedata[3:0];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_status_ff  <= 4'h0;
         self_full_q_ff <= 1'b0;
         cpu_full_q_ff  <= 1'b0;
         stall_q_ff     <= 1'b0;
      end else begin
         irq_status_ff  <= nxt_irq_status;
         self_full_q_ff <= self_queue_full;
         cpu_full_q_ff  <= cpu_queue_full;
         stall_q_ff     <= kernel_stall;
      end
   end

endmodule

`default_nettype wire

/* File: design/crq_pkg.sv */
// Constants and types of the implicit request queues block.
// Assumes one system clock domain and word-indexed Avalon-MM addressing.
package crq_pkg;

   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned PRIO_W = 8;
   localparam int unsigned IRQ_W  = 4;

   // Register word indices; byte address is four times the index
   localparam logic [3:0] IDX_NODE0       = 4'h0;
   localparam logic [3:0] IDX_NODE3       = 4'h3;
   localparam logic [3:0] IDX_ARB_CTRL    = 4'h4;
   localparam logic [3:0] IDX_GLOBAL_CTRL = 4'h5;
   localparam logic [3:0] IDX_ARB_STATUS  = 4'h6;
   localparam logic [3:0] IDX_IRQ_STATUS  = 4'h7;
   localparam logic [3:0] IDX_IRQ_MASK    = 4'h8;

   // Node word layout
   localparam int unsigned NODE_PRIO_LSB = 0;
   localparam int unsigned NODE_TOS_LSB  = 10;
   localparam int unsigned NODE_EN_BIT   = 12;
   localparam int unsigned NODE_PEND_BIT = 13;

   localparam logic [1:0] TOS_CPU    = 2'h0;
   localparam logic [1:0] TOS_SELF   = 2'h1;
   localparam logic       EN_FIXED   = 1'b1;

   // Arbitration control: cycles per round minus one, one-clock cycles
   localparam int unsigned ARB_CNT_LSB = 0;
   localparam int unsigned ARB_ONE_BIT = 2;
   localparam logic [2:0]  ARB_CTRL_RST = 3'h4;

   // Global control: error request priority
   localparam int unsigned ERR_PRIO_LSB = 0;
   localparam logic [7:0]  ERR_PRIO_RST = 8'h00;

   // Arbitration status layout
   localparam int unsigned ST_WIN_LSB    = 0;
   localparam int unsigned ST_WIN_VALID  = 8;
   localparam int unsigned ST_SELF_FULL  = 9;
   localparam int unsigned ST_CPU_FULL   = 10;
   localparam int unsigned ST_STALL      = 11;
   localparam int unsigned ST_SPECIAL    = 12;
   localparam int unsigned ST_SRC_LSB    = 16;

   // Interrupt status bits
   localparam int unsigned IRQ_CPU_FULL  = 0;
   localparam int unsigned IRQ_SELF_FULL = 1;
   localparam int unsigned IRQ_STALL     = 2;
   localparam int unsigned IRQ_SPECIAL   = 3;
   localparam logic [3:0]  IRQ_MASK_RST  = 4'h0;

   // Arbitration winner source
   localparam logic [1:0] SRC_NODE2 = 2'h0;
   localparam logic [1:0] SRC_NODE3 = 2'h1;
   localparam logic [1:0] SRC_EXT   = 2'h2;

   typedef enum logic [1:0] {
      ARB_IDLE,
      ARB_RUN,
      ARB_HOLD
   } crq_arb_e;

   typedef struct packed {
      logic             pend;
      logic [PRIO_W-1:0] prio;
   } crq_node_s;

   typedef struct packed {
      logic             from_error;
      logic             int_bit;
      logic             cond_true;
      logic [1:0]       target;
      logic [PRIO_W-1:0] prio;
   } crq_post_s;

endpackage

/* File: testbench/crq_request_queues_props.sv */
// Checker for the implicit request queues, bound to the top module.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module crq_request_queues_props (
   input wire logic                     clk,
   input wire logic                     rst_n,
   input wire logic                     post_req,
   input wire crq_pkg::crq_post_s       post_info,
   input wire logic                     post_ack,
   input wire logic                     kernel_stall,
   input wire logic                     cpu_queue_full,
   input wire logic                     self_queue_full,
   input wire crq_pkg::crq_node_s [1:0] cpu_nodes,
   input wire logic [1:0]               cpu_ack,
   input wire logic                     kernel_accept,
   input wire logic                     winner_valid,
   input wire logic [7:0]               pending_winner_priority,
   input wire logic [1:0]               winner_src,
   input wire logic                     ext_ack
);
   default clocking dc @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Errors always count as valid and ignore the target field
   wire logic vld = post_info.from_error
                  || (post_info.int_bit && post_info.cond_true);
   wire logic cpu_rt = post_info.from_error
                     || post_info.target != crq_pkg::TOS_SELF;
   sequence s_take_cpu;
      post_ack && vld && cpu_rt && cpu_ack == 2'h0;
   endsequence
   sequence s_exit_take;
      s_take_cpu ##0 !post_info.from_error;
   endsequence
   a_full_flag: assert property (
      cpu_queue_full == (cpu_nodes[0].pend && cpu_nodes[1].pend))
      else $error("cpu queue full flag wrong");
   a_ack_rule: assert property (post_ack == (post_req && !kernel_stall))
      else $error("post taken while stalled");
   a_stall_cause: assert property (
      kernel_stall |-> post_req && vld
         && (cpu_rt ? cpu_queue_full : self_queue_full))
      else $error("stall without a full target queue");
   a_no_early_stall: assert property (
      post_req && vld && cpu_rt && !cpu_queue_full |-> !kernel_stall)
      else $error("stall while cpu queue has room");
   a_first_node: assert property (
      s_exit_take ##0 !cpu_nodes[0].pend |=> cpu_nodes[0].pend
         && cpu_nodes[0].prio == $past(post_info.prio))
      else $error("node0 not loaded");
   a_second_node: assert property (
      s_exit_take ##0 cpu_nodes[0].pend && !cpu_nodes[1].pend
         |=> cpu_nodes[1].pend && cpu_nodes[1].prio == $past(post_info.prio))
      else $error("node1 not loaded");
   a_error_post: assert property (
      s_take_cpu ##0 post_info.from_error |=> cpu_queue_full
         || (cpu_nodes[0].pend ^ cpu_nodes[1].pend))
      else $error("error request not queued for cpu");
   a_invalid_post: assert property (
      post_ack && !vld && cpu_ack == 2'h0 |=> $stable(cpu_nodes))
      else $error("invalid exit changed a node");
   a_ack_frees: assert property (
      cpu_ack[0] && cpu_nodes[0].pend |=> !cpu_nodes[0].pend)
      else $error("acknowledge did not free node0");
   a_win_holds: assert property (
      winner_valid && !kernel_accept && winner_src != crq_pkg::SRC_EXT
         |=> winner_valid && $stable(pending_winner_priority))
      else $error("winner dropped before accept");
   a_self_only: assert property (
      $rose(winner_valid) && $past(self_queue_full)
         |-> winner_src != crq_pkg::SRC_EXT)
      else $error("external winner while self queue full");
   a_ext_ack: assert property (
      kernel_accept && winner_valid && winner_src == crq_pkg::SRC_EXT
         |-> ext_ack)
      else $error("external winner not acknowledged");
endmodule
bind crq_request_queues crq_request_queues_props props_u (
   .clk(clk), .rst_n(rst_n), .post_req(post_req), .post_info(post_info),
   .post_ack(post_ack), .kernel_stall(kernel_stall),
   .cpu_queue_full(cpu_queue_full), .self_queue_full(self_queue_full),
   .cpu_nodes(cpu_nodes), .cpu_ack(cpu_ack), .kernel_accept(kernel_accept),
   .winner_valid(winner_valid), .winner_src(winner_src),
   .pending_winner_priority(pending_winner_priority), .ext_ack(ext_ack));
`default_nettype wire

/* File: testbench/crq_arb_partner.sv */
// Model of the cpu arbiter and the coprocessor kernel acceptance.
// Assumes pulses last one clk cycle; hold inputs let the bench stall it.
`timescale 1ns/1ps
`default_nettype none
module crq_arb_partner (
   input wire logic                     clk,
   input wire logic                     rst_n,
   input wire crq_pkg::crq_node_s [1:0] cpu_nodes,
   input wire logic                     winner_valid,
   input wire logic                     hold_cpu,
   input wire logic                     hold_self,
   input wire logic                     slow,
   output var logic [1:0]               cpu_ack,
   output var logic                     kernel_accept
);
   logic [3:0] wait_ff;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cpu_ack <= 2'h0;
         kernel_accept <= 1'b0;
         wait_ff <= 4'h0;
      end else begin
         cpu_ack <= 2'h0;
         kernel_accept <= 1'b0;
         wait_ff <= (wait_ff != 4'h0) ? wait_ff - 4'h1 : (slow ? 4'h5 : 4'h0);
         // Previous pulse blocks a second acknowledge of the same node
         if (wait_ff == 4'h0 && cpu_ack == 2'h0 && !hold_cpu) begin
            if (cpu_nodes[0].pend)
               cpu_ack <= 2'h1;
            else if (cpu_nodes[1].pend)
               cpu_ack <= 2'h2;
         end
         if (wait_ff == 4'h0 && !kernel_accept && winner_valid && !hold_self)
            kernel_accept <= 1'b1;
      end
   end
endmodule
`default_nettype wire

/* File: testbench/crq_request_queues_tb.sv */
// Self-checking bench of the implicit request queues.
// Assumes the partner model answers the cpu and kernel side.
`timescale 1ns/1ps
`default_nettype none
module crq_request_queues_tb;
   logic clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rdat, rnd;
   logic avs_waitrequest, post_req = 1'b0, post_ack, kernel_stall, irq;
   logic cpu_queue_full, self_queue_full, ext_req = 1'b0, ext_ack;
   logic kernel_accept, winner_valid, hold_cpu = 1'b1, hold_self = 1'b1;
   logic slow = 1'b0;
   logic [1:0] cpu_ack, winner_src;
   logic [7:0] ext_prio = 8'h0, pending_winner_priority, err_prio, pr;
   crq_pkg::crq_post_s post_info = '0;
   crq_pkg::crq_node_s [1:0] cpu_nodes;
   integer seed = 73, failures = 0, n_checks = 0, cyc = 0, i;
   always #50 clk = ~clk;
   crq_request_queues dut_u (.clk(clk), .rst_n(rst_n),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .post_req(post_req), .post_info(post_info), .post_ack(post_ack),
      .kernel_stall(kernel_stall), .cpu_queue_full(cpu_queue_full),
      .self_queue_full(self_queue_full), .cpu_nodes(cpu_nodes),
      .cpu_ack(cpu_ack), .ext_req(ext_req), .ext_prio(ext_prio),
      .ext_ack(ext_ack), .kernel_accept(kernel_accept),
      .winner_valid(winner_valid), .winner_src(winner_src),
      .pending_winner_priority(pending_winner_priority), .irq(irq));
   crq_arb_partner partner_u (.clk(clk), .rst_n(rst_n), .cpu_nodes(cpu_nodes),
      .winner_valid(winner_valid), .hold_cpu(hold_cpu),
      .hold_self(hold_self), .slow(slow), .cpu_ack(cpu_ack),
      .kernel_accept(kernel_accept));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks = n_checks + 1;
      if (got !== exp) begin
         failures = failures + 1;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Request held through the edge that sees waitrequest low, then dropped
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) begin
         n = n + 1;
         @(posedge clk);
      end
      check(n, 32'h1);
      rdat = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic post(input crq_pkg::crq_post_s p);
      @(posedge clk);
      post_req <= 1'b1;
      post_info <= p;
      @(posedge clk);
      while (post_ack !== 1'b1)
         @(posedge clk);
      check({31'h0, post_ack}, 32'h1);
      post_req <= 1'b0;
   endtask
   function automatic logic [31:0] node_w(input logic p, input logic [1:0] t,
                                          input logic [7:0] v);
      node_w = {18'h0, p, crq_pkg::EN_FIXED, t, 2'h0, v};
   endfunction
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 30000) begin
         failures = failures + 1;
         summarize();
      end
   end
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      for (i = 0; i < 4; i = i + 1) begin
         bus(1'b1, i[3:0], 32'hffffffff);
         bus(1'b0, i[3:0], 32'h0);
         check(rdat, node_w(1'b0, i < 2 ? 2'h0 : 2'h1, 8'h0));
      end
      bus(1'b0, crq_pkg::IDX_ARB_CTRL, 32'h0);
      check(rdat, {29'h0, crq_pkg::ARB_CTRL_RST});
      bus(1'b0, 4'hf, 32'h0);
      check(rdat, 32'h0);
      rnd = $random(seed);
      err_prio = rnd[7:0];
      pr = rnd[15:8];
      bus(1'b1, crq_pkg::IDX_GLOBAL_CTRL, {24'h0, err_prio});
      bus(1'b1, crq_pkg::IDX_IRQ_MASK, 32'hf);
      post('{1'b1, 1'b0, 1'b0, 2'h1, 8'h0});
      post('{1'b0, 1'b1, 1'b1, 2'h0, pr});
      bus(1'b0, 4'h0, 32'h0);
      check(rdat, node_w(1'b1, 2'h0, err_prio));
      bus(1'b0, 4'h1, 32'h0);
      check(rdat, node_w(1'b1, 2'h0, pr));
      check({31'h0, irq}, 32'h1);
      bus(1'b0, crq_pkg::IDX_IRQ_STATUS, 32'h0);
      check(rdat, 32'h1);
      post('{1'b0, 1'b0, 1'b1, 2'h0, 8'h33});
      bus(1'b0, crq_pkg::IDX_IRQ_STATUS, 32'h0);
      check(rdat, 32'h0);
      check({31'h0, irq}, 32'h0);
      fork
         post('{1'b0, 1'b1, 1'b1, 2'h3, 8'h5a});
         begin
            repeat (20) @(negedge clk);
            check({30'h0, kernel_stall, post_ack}, 32'h2);
            @(posedge clk);
            hold_cpu <= 1'b0;
         end
      join
      bus(1'b0, crq_pkg::IDX_IRQ_STATUS, 32'h0);
      check(rdat & 32'h4, 32'h4);
      ext_prio <= 8'hff;
      ext_req <= 1'b1;
      post('{1'b0, 1'b1, 1'b1, 2'h1, 8'hf0});
      post('{1'b0, 1'b1, 1'b1, 2'h1, 8'hf1});
      repeat (10) @(posedge clk);
      check({21'h0, winner_valid, winner_src, pending_winner_priority},
            {21'h0, 1'b1, crq_pkg::SRC_NODE3, 8'hf1});
      bus(1'b0, 4'h2, 32'h0);
      check(rdat, node_w(1'b1, 2'h1, 8'hf0));
      hold_self <= 1'b0;
      rnd = $random(seed);
      bus(1'b1, crq_pkg::IDX_ARB_CTRL, {29'h0, rnd[2:0]});
      bus(1'b0, crq_pkg::IDX_ARB_CTRL, 32'h0);
      check(rdat, {29'h0, rnd[2:0]});
      slow <= 1'b1;
      for (i = 0; i < 40; i = i + 1) begin
         rnd = $random(seed);
         ext_req <= rnd[31];
         ext_prio <= rnd[23:16];
         post(rnd[12:0]);
      end
      summarize();
   end
endmodule
`default_nettype wire
